// ==== conv_status_pkg.sv ====
/*
 * constants shared by the conversion status i2c target and its byte engine.
 * assumes nothing of its surroundings.
 */
package conv_status_pkg;
	// command bytes
	localparam logic [7:0] CMD_READ_RESULT = 8'h10;
	localparam logic [7:0] CMD_REG_READ = 8'h20;
	localparam logic [7:0] CMD_REG_WRITE = 8'h40;
	localparam logic [7:0] CMD_OP_MASK = 8'hf8;
	localparam int CMD_REG_SEL_BIT = 2;
	// register map
	localparam logic REG_CONFIG = 1'h0;
	localparam logic REG_STATUS = 1'h1;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int STATUS_READY_BIT = 7;
	localparam logic [6:0] STATUS_RESERVED_VALUE = 7'h00;
	// result framing
	localparam int RESULT_WIDTH = 24;
	localparam logic [1:0] RESULT_BYTES = 2'h3;
	localparam logic [7:0] RESULT_PAD = 8'h00;
	// bit engine
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] ADDR_BASE_DEFAULT = 3'h4;
endpackage : conv_status_pkg

// ==== conversion_status_flag_i2c_target.sv ====
/*
 * converter i2c target: command decode, config and status registers,
 * conversion ready flag and open-drain ready pin.
 * assumes the converter gives a one-cycle conv_done with conv_data valid,
 * and that scl and sda are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module conversion_status_flag_i2c_target #(
	parameter logic [2:0] ADDR_BASE = conv_status_pkg::ADDR_BASE_DEFAULT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [1:0] address_select_pin_low,
	input wire logic [1:0] address_select_pin_high,
	input wire logic conv_done,
	input wire logic [23:0] conv_data,
	output logic [7:0] config_o,
	output logic conversion_ready_o,
	output logic conversion_ready_oe
);
	typedef enum logic [1:0] {
		SRC_REG = 2'h1,
		SRC_RESULT = 2'h2
	} tx_src_t;

	localparam int RW = conv_status_pkg::RESULT_WIDTH;

	i2c_byte_if b ();

	tx_src_t src_r, src_nxt;
	logic [7:0] config_r, config_nxt, tx_r, tx_nxt;
	logic ready_r, ready_nxt, reg_sel_r, reg_sel_nxt;
	logic first_r, first_nxt, wr_pend_r, wr_pend_nxt, wr_sel_r, wr_sel_nxt;
	logic [RW-1:0] result_r, result_nxt, out_r, out_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic [7:0] cmd_op;

	// pin levels: gnd, vdd, sda, scl each give one code per pin
	i2c_target_bytes u_bytes (
		.clk(clk),
		.rst_n(rst_n),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.own_addr({ADDR_BASE, address_select_pin_high,
			address_select_pin_low}),
		.b(b)
	);
	// no scl output exists at all: the bus clock is never held low

	function automatic logic [7:0] reg_value(input logic sel,
		input logic [7:0] cfg, input logic rdy);
		if (sel == conv_status_pkg::REG_STATUS)
			reg_value = {rdy, conv_status_pkg::STATUS_RESERVED_VALUE};
		else
			reg_value = cfg;
	endfunction : reg_value

	function automatic logic [7:0] result_byte(input logic [RW-1:0] r,
		input logic [1:0] i);
		case (i)
		2'h0: result_byte = r[23:16];
		2'h1: result_byte = r[15:8];
		2'h2: result_byte = r[7:0];
		default: result_byte = conv_status_pkg::RESULT_PAD;
		endcase
	endfunction : result_byte

	function automatic logic [7:0] next_tx(input tx_src_t s,
		input logic [RW-1:0] r, input logic [1:0] i, input logic sel,
		input logic [7:0] cfg, input logic rdy);
		if (s == SRC_RESULT)
			next_tx = result_byte(r, i);
		else
			next_tx = reg_value(sel, cfg, rdy);
	endfunction : next_tx

	assign b.tx_data = tx_r;
	assign cmd_op = b.rx_data & conv_status_pkg::CMD_OP_MASK;
	assign config_o = config_r;
	assign conversion_ready_o = 1'h0;
	assign conversion_ready_oe = ready_r;

	always_comb begin
		src_nxt = src_r;
		config_nxt = config_r;
		tx_nxt = tx_r;
		reg_sel_nxt = reg_sel_r;
		first_nxt = first_r;
		wr_pend_nxt = wr_pend_r;
		wr_sel_nxt = wr_sel_r;
		result_nxt = result_r;
		out_nxt = out_r;
		idx_nxt = idx_r;
		ready_nxt = ready_r;
		if (conv_done)
			result_nxt = conv_data;
		// clear on first result byte out; a fresh result that cycle wins
		if (b.tx_take && src_r == SRC_RESULT && idx_r == 2'h0)
			ready_nxt = 1'h0;
		if (conv_done)
			ready_nxt = 1'h1;
		if (b.sel) begin
			if (b.rw) begin
				idx_nxt = 2'h0;
				tx_nxt = next_tx(src_r, out_r, 2'h0, reg_sel_r, config_r,
					ready_r);
			end else begin
				first_nxt = 1'h1;
				wr_pend_nxt = 1'h0;
			end
		end
		if (b.tx_take) begin
			if (idx_r != conv_status_pkg::RESULT_BYTES)
				idx_nxt = idx_r + 2'h1;
			tx_nxt = next_tx(src_r, out_r, idx_nxt, reg_sel_r, config_r,
				ready_nxt);
		end
		if (b.rx_valid) begin
			if (first_r) begin
				first_nxt = 1'h0;
				if (b.rx_data == conv_status_pkg::CMD_READ_RESULT) begin
					src_nxt = SRC_RESULT;
					out_nxt = result_r;
				end else if (cmd_op == conv_status_pkg::CMD_REG_READ) begin
					src_nxt = SRC_REG;
					reg_sel_nxt = b.rx_data[conv_status_pkg::CMD_REG_SEL_BIT];
				end else if (cmd_op == conv_status_pkg::CMD_REG_WRITE) begin
					wr_pend_nxt = 1'h1;
					wr_sel_nxt = b.rx_data[conv_status_pkg::CMD_REG_SEL_BIT];
				end
			end else if (wr_pend_r) begin
				wr_pend_nxt = 1'h0;
				// status is read-only; a write to it is dropped
				if (wr_sel_r == conv_status_pkg::REG_CONFIG)
					config_nxt = b.rx_data;
			end
		end
		if (b.stop) begin
			first_nxt = 1'h0;
			wr_pend_nxt = 1'h0;
		end
	end

	// only rst_n resets these; nothing tied to power-down touches them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_r <= SRC_REG;
			config_r <= conv_status_pkg::CONFIG_RESET;
			ready_r <= conv_status_pkg::STATUS_RESET[conv_status_pkg::STATUS_READY_BIT];
			tx_r <= 8'h00;
			reg_sel_r <= conv_status_pkg::REG_CONFIG;
			first_r <= 1'h0;
			wr_pend_r <= 1'h0;
			wr_sel_r <= conv_status_pkg::REG_CONFIG;
			result_r <= '0;
			out_r <= '0;
			idx_r <= 2'h0;
		end else begin
			src_r <= src_nxt;
			config_r <= config_nxt;
			ready_r <= ready_nxt;
			tx_r <= tx_nxt;
			reg_sel_r <= reg_sel_nxt;
			first_r <= first_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_sel_r <= wr_sel_nxt;
			result_r <= result_nxt;
			out_r <= out_nxt;
			idx_r <= idx_nxt;
		end
	end
endmodule : conversion_status_flag_i2c_target
`default_nettype wire

// ==== conversion_status_flag_i2c_target_assertions.sv ====
/* ready flag and pin checks on the top ports.
 * assumes one clock and the active low reset. */
`timescale 1ns/1ps
`default_nettype none
module csf_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic conv_done,
	input wire logic [7:0] config_o,
	input wire logic conversion_ready_o,
	input wire logic conversion_ready_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_set; conv_done |=> conversion_ready_oe; endproperty
	a_set: assert property (p_set) else $error("flag not set");
	property p_cause; $rose(conversion_ready_oe) |-> $past(conv_done);
	endproperty
	a_cause: assert property (p_cause) else $error("flag set alone");
	property p_keep; $fell(conversion_ready_oe) |-> !$past(conv_done);
	endproperty
	a_keep: assert property (p_keep) else $error("set lost");
	// a clear only follows a cycle with scl_i low
	property p_hold; conversion_ready_oe && scl_i |=> conversion_ready_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("early clear");
	property p_ack; $rose(sda_oe) |-> !$past(scl_i); endproperty
	a_ack: assert property (p_ack) else $error("sda moved, scl high");
	property p_cfg; $changed(config_o) |-> !$past(scl_i); endproperty
	a_cfg: assert property (p_cfg) else $error("config off slot");
	property p_pin; conversion_ready_o == 1'h0; endproperty
	a_pin: assert property (p_pin) else $error("ready pin driven");
	property p_sda; sda_o == 1'h0; endproperty
	a_sda: assert property (p_sda) else $error("sda driven high");
	c_done: cover property (conv_done);
	c_clr: cover property ($fell(conversion_ready_oe));
	c_cfg: cover property ($changed(config_o));
endmodule : csf_chk
bind conversion_status_flag_i2c_target csf_chk u_chk (.clk(clk),
	.rst_n(rst_n), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.conv_done(conv_done), .config_o(config_o),
	.conversion_ready_o(conversion_ready_o),
	.conversion_ready_oe(conversion_ready_oe));
`default_nettype wire

// ==== conversion_status_flag_i2c_target_tb.sv ====
/* self-checking bench for the conversion status target.
 * assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module conversion_status_flag_i2c_target_tb;
	logic clk, rst_n, conv_done, sda_oe, rdy_oe, sda_o, rdy_o, scl, sda_low;
	logic [1:0] pl, ph;
	logic [23:0] cdata;
	logic [7:0] cfg;
	int error_cnt, total_checks;
	int cyc = 0;
	wire logic sda = !(sda_low | sda_oe);
	wire logic rdy_pin = !rdy_oe; // pullup gives the high level
	wire logic [6:0] own = {conv_status_pkg::ADDR_BASE_DEFAULT, ph, pl};
	conversion_status_flag_i2c_target dut (.clk(clk), .rst_n(rst_n),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.address_select_pin_low(pl), .address_select_pin_high(ph),
		.conv_done(conv_done), .conv_data(cdata), .config_o(cfg),
		.conversion_ready_o(rdy_o), .conversion_ready_oe(rdy_oe));
	i2c_ctrl_model m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic hdr(input logic [6:0] ta, input logic r);
		logic [7:0] q;
		logic a;
		m.start();
		m.xfer({ta, r}, 1'h1, q, a);
		chk(24'(a), 24'(ta !== own));
	endtask : hdr
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] q;
		logic a;
		hdr(own, 1'h0);
		m.xfer(c, 1'h1, q, a);
		if (c[6]) m.xfer(d, 1'h1, q, a);
		m.stop();
	endtask : wr
	task automatic rd(input int n, output logic [23:0] v);
		logic [7:0] q;
		logic a;
		v = 24'h0;
		hdr(own, 1'h1);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hff, i == n - 1, q, a);
			v = {v[15:0], q};
		end
		m.stop();
	endtask : rd
	task automatic register_read_command(input logic [7:0] c, input logic [7:0] e);
		logic [23:0] v;
		wr(c, 8'h00);
		rd(1, v);
		chk(v, 24'(e));
	endtask : register_read_command
	task automatic conv(input logic [23:0] d);
		cdata <= d;
		conv_done <= 1'h1;
		@(posedge clk);
		conv_done <= 1'h0;
		@(posedge clk);
	endtask : conv
	task automatic t_reset();
		m.hp_n = 8;
		chk(24'(cfg), 24'h0);
		chk(24'(rdy_pin), 24'h1);
		register_read_command(8'h24, 8'h00);
		m.hp_n = 4;
	endtask : t_reset
	task automatic t_cfg();
		wr(8'h40, 8'h55);
		chk(24'(cfg), 24'h55);
		wr(8'h44, 8'haa); // status is read only, write dropped
		register_read_command(8'h20, 8'h55);
		register_read_command(8'h24, 8'h00);
	endtask : t_cfg
	task automatic t_data();
		logic [23:0] v;
		conv(24'ha5c3e1);
		chk(24'(rdy_pin), 24'h0);
		conv(24'h123456);
		register_read_command(8'h24, 8'h80);
		wr(8'h10, 8'h00);
		rd(3, v);
		chk(v, 24'h123456);
		chk(24'(rdy_pin), 24'h1);
		register_read_command(8'h24, 8'h00);
	endtask : t_data
	task automatic t_mid();
		logic [23:0] v;
		conv(24'h111111);
		wr(8'h10, 8'h00);
		// new result lands after the first byte load, mid read
		fork
			rd(3, v);
			begin
				repeat (250) @(posedge clk);
				conv(24'h222222);
			end
		join
		chk(v, 24'h111111);
		chk(24'(rdy_pin), 24'h0);
		wr(8'h10, 8'h00);
		rd(3, v);
		chk(v, 24'h222222);
	endtask : t_mid
	task automatic t_addr();
		m.hp_n = 2;
		for (int i = 0; i < 16; i++) begin
			pl <= i[1:0];
			ph <= i[3:2];
			@(posedge clk);
			// write header: a read may hold sda low and block the stop
			hdr(own, 1'h0);
			m.stop();
			hdr(own ^ 7'h01, 1'h0);
			m.stop();
		end
	endtask : t_addr
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// cut a hang: whole run is well under this many cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			finish_test();
		end
	end
	initial begin
		rst_n = 1'h0;
		conv_done = 1'h0;
		cdata = 24'h0;
		pl = 2'h1;
		ph = 2'h2;
		error_cnt = 0;
		total_checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		t_reset();
		t_cfg();
		t_data();
		t_mid();
		t_addr();
		finish_test();
	end
endmodule : conversion_status_flag_i2c_target_tb
`default_nettype wire

// ==== i2c_byte_if.sv ====
/*
 * byte level link between the i2c bit engine and the command logic.
 * assumes both sides run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface i2c_byte_if;
	logic sel;
	logic rw;
	logic rx_valid;
	logic [7:0] rx_data;
	logic tx_take;
	logic [7:0] tx_data;
	logic stop;
	modport engine (
		output sel,
		output rw,
		output rx_valid,
		output rx_data,
		output tx_take,
		output stop,
		input tx_data
	);
	modport cmd (
		input sel,
		input rw,
		input rx_valid,
		input rx_data,
		input tx_take,
		input stop,
		output tx_data
	);
endinterface : i2c_byte_if
`default_nettype wire

// ==== i2c_ctrl_model.sv ====
/* i2c controller model: drives scl, pulls sda low.
 * assumes sda is the resolved wire with pullup. */
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	int hp_n = 4; // quarter of an scl period in clocks, set fast or slow
	initial begin
		scl = 1'h1; // only this side ever drives scl
		sda_low = 1'h0;
	end
	task automatic hp();
		repeat (hp_n) @(posedge clk);
	endtask : hp
	task automatic bitx(input logic b, output logic r);
		sda_low <= !b;
		hp();
		scl <= 1'h1;
		hp();
		r = sda;
		hp();
		scl <= 1'h0;
		hp();
	endtask : bitx
	task automatic start();
		sda_low <= 1'h0;
		hp();
		scl <= 1'h1;
		hp();
		sda_low <= 1'h1;
		hp();
		scl <= 1'h0;
		hp();
	endtask : start
	task automatic stop();
		sda_low <= 1'h1;
		hp();
		scl <= 1'h1;
		hp();
		sda_low <= 1'h0;
		hp();
	endtask : stop
	// last is the ninth bit sent: 1 releases for ack or nacks a read
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(last, a);
	endtask : xfer
endmodule : i2c_ctrl_model
`default_nettype wire

// ==== i2c_target_bytes.sv ====
/*
 * i2c target bit engine: start/stop detect, address match, ack, byte shift.
 * assumes scl and sda are synchronous to clk and oversampled by far.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_target_bytes (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [6:0] own_addr,
	i2c_byte_if.engine b
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ACK_A = 7'h04,
		ST_WRITE = 7'h08,
		ST_ACK_W = 7'h10,
		ST_READ = 7'h20,
		ST_ACK_R = 7'h40
	} bit_state_t;

	bit_state_t st_r, st_nxt;
	logic scl_q_r, sda_q_r, oe_r, oe_nxt, mack_r, mack_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic rise, fall, start, stop, done;

	assign rise = scl_i & ~scl_q_r;
	assign fall = ~scl_i & scl_q_r;
	assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
	assign stop = scl_i & scl_q_r & ~sda_q_r & sda_i;
	assign done = (cnt_r == conv_status_pkg::BITS_PER_BYTE);
	assign sda_o = 1'h0;
	assign sda_oe = oe_r;
	assign b.rw = sh_r[0];
	assign b.rx_data = sh_r;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		oe_nxt = oe_r;
		mack_nxt = mack_r;
		b.sel = 1'h0;
		b.rx_valid = 1'h0;
		b.tx_take = 1'h0;
		b.stop = 1'h0;
		if (start) begin
			st_nxt = ST_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt = 1'h0;
		end else if (stop) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'h0;
			b.stop = 1'h1;
		end else begin
			case (st_r)
			ST_IDLE: begin
			end
			ST_ADDR, ST_WRITE: begin
				if (rise && !done) begin
					sh_nxt = {sh_r[6:0], sda_i};
					cnt_nxt = cnt_r + 4'h1;
				end
				if (fall && done) begin
					if (st_r == ST_WRITE) begin
						b.rx_valid = 1'h1;
						oe_nxt = 1'h1;
						st_nxt = ST_ACK_W;
					end else if (sh_r[7:1] == own_addr) begin
						b.sel = 1'h1;
						oe_nxt = 1'h1;
						st_nxt = ST_ACK_A;
					end else begin
						st_nxt = ST_IDLE;
					end
				end
			end
			ST_ACK_A, ST_ACK_W, ST_ACK_R: begin
				if (rise && st_r == ST_ACK_R)
					mack_nxt = ~sda_i;
				if (fall) begin
					cnt_nxt = 4'h0;
					if ((st_r == ST_ACK_A && sh_r[0]) ||
					    (st_r == ST_ACK_R && mack_r)) begin
						sh_nxt = b.tx_data;
						oe_nxt = ~b.tx_data[7];
						b.tx_take = 1'h1;
						st_nxt = ST_READ;
					end else if (st_r == ST_ACK_R) begin
						oe_nxt = 1'h0;
						st_nxt = ST_IDLE;
					end else begin
						oe_nxt = 1'h0;
						st_nxt = ST_WRITE;
					end
				end
			end
			ST_READ: begin
				if (rise && !done)
					cnt_nxt = cnt_r + 4'h1;
				if (fall) begin
					if (done) begin
						oe_nxt = 1'h0;
						st_nxt = ST_ACK_R;
					end else begin
						sh_nxt = {sh_r[6:0], 1'h0};
						oe_nxt = ~sh_r[6];
					end
				end
			end
			default: begin
				st_nxt = ST_IDLE;
				oe_nxt = 1'h0;
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			oe_r <= 1'h0;
			mack_r <= 1'h0;
			scl_q_r <= 1'h1;
			sda_q_r <= 1'h1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			oe_r <= oe_nxt;
			mack_r <= mack_nxt;
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
		end
	end
endmodule : i2c_target_bytes
`default_nettype wire
